//--- rtl/dpc_pkg.sv
package dpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and sizes
  ////////////////////////////////////////////////////////////////////////////
  localparam int X_W       = 12;  // Column coordinate width
  localparam int Y_W       = 12;  // Row coordinate width
  localparam int PIX_W     = 12;  // Pixel sample width
  localparam int TBL_DEPTH = 16;  // Default table capacity
  localparam int BUF_DEPTH = 2;   // Output buffer entries

  ////////////////////////////////////////////////////////////////////////////
  // Types
  ////////////////////////////////////////////////////////////////////////////
  // One table entry, full-frame position
  typedef struct packed {
    logic [X_W-1:0] x;
    logic [Y_W-1:0] y;
  } coord_s;

  // One pixel beat of the stream
  typedef struct packed {
    logic             sof;   // First pixel of a frame
    logic             eol;   // Last pixel of a line
    logic             eof;   // Last pixel of a frame
    logic [PIX_W-1:0] data;  // Sample value
  } pix_beat_s;

  // Replacement method
  typedef enum logic {
    MODE_AVERAGE,
    MODE_HIGHLIGHT
  } corr_mode_e;

  ////////////////////////////////////////////////////////////////////////////
  // Factory calibrated list
  ////////////////////////////////////////////////////////////////////////////
  localparam int     FACTORY_N = 2;           // Entries in factory list
  localparam coord_s FACTORY_TBL [FACTORY_N] = '{
    '{x: 12'h010, y: 12'h008},
    '{x: 12'h123, y: 12'h045}
  };

endpackage

//--- rtl/pix_skid_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module pix_skid_fifo #(
  parameter int W     = 8,  // Word width
  parameter int DEPTH = 2   // Number of entries
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Fill side
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  // Drain side
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];  // Storage
  logic [PW-1:0] wr_q;         // Write pointer
  logic [PW-1:0] rd_q;         // Read pointer
  logic [CW-1:0] cnt_q;        // Occupancy
  logic          push;
  logic          pop;

  // Honest full and empty
  assign o_ready = (cnt_q != CW'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = mem[rd_q];

  ////////////////////////////////////////////////////////////////////////////
  // Storage write
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_q] <= i_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

//--- rtl/defective_pixel_corrector.sv
// Functional notes
// - One enable switches listed-pixel replacement on/off
// - Listed pixels get a mode-dependent substitute
// - Average mode outputs mean of neighbours
// - Highlight mode forces format maximum value
// - Writable entry count sizes working list
// - Index is zero-based, valid 0..N-1
// - Selected entry X and Y readable, writable
// - Coordinates refer to full sensor frame
// - Edits touch working copy until apply
// - Apply copies working list to volatile table
// - Save writes storage; boot loads it
// - Save overwrites stored list entirely
// - Restore loads factory list everywhere
// - Device ships with factory defect list
// - Transfer during streaming waits for frame end, no glitch
`timescale 1ns/1ps
`default_nettype none

module defective_pixel_corrector
  import dpc_pkg::*;
#(
  parameter int DEPTH = TBL_DEPTH  // Table capacity
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Pixel stream in
  input  wire logic             i_valid,
  input  wire pix_beat_s        i_beat,
  output logic                  o_ready,
  // Pixel stream out
  output logic                  o_valid,
  output pix_beat_s             o_beat,
  input  wire logic             i_ready,
  // Correction control
  input  wire logic             i_enable,
  input  wire corr_mode_e       i_mode,
  input  wire logic [PIX_W-1:0] i_pix_max,
  input  wire logic [X_W-1:0]   i_roi_off_x,
  input  wire logic [Y_W-1:0]   i_roi_off_y,
  // Table editing
  input  wire logic             i_count_wr,
  input  wire logic [$clog2(DEPTH+1)-1:0] i_count,
  output logic [$clog2(DEPTH+1)-1:0]      o_count,
  input  wire logic [$clog2(DEPTH)-1:0]   i_index,
  output logic                  o_index_err,
  input  wire logic             i_x_wr,
  input  wire logic [X_W-1:0]   i_x,
  input  wire logic             i_y_wr,
  input  wire logic [Y_W-1:0]   i_y,
  output logic [X_W-1:0]        o_x,
  output logic [Y_W-1:0]        o_y,
  // Table commands
  input  wire logic             i_apply,
  input  wire logic             i_save,
  input  wire logic             i_restore,
  input  wire logic             i_nvm_fresh,
  output logic                  o_busy
);

  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_BOOT,
    ST_IDLE,
    ST_APPLY,
    ST_SAVE,
    ST_RESTORE
  } copy_st_e;

  copy_st_e      st_q;                // Copy engine state
  logic [IW-1:0] idx_q;               // Copy position
  logic          last;                // Final copy step
  logic          boot_go;             // Boot copies stored list

  coord_s        work_q  [DEPTH];     // Working copy, edited
  coord_s        stage_q [DEPTH];     // Applied, awaiting swap
  coord_s        act_q   [DEPTH];     // Table used on pixels
  coord_s        nvm_q   [DEPTH];     // Persistent list
  logic [CW-1:0] work_cnt_q;          // Working entry count
  logic [CW-1:0] stage_cnt_q;         // Staged entry count
  logic [CW-1:0] act_cnt_q;           // Active entry count
  logic [CW-1:0] nvm_cnt_q;           // Stored entry count
  logic          pend_q;              // Staged table waiting
  logic          stage_done;          // Stage copy finished
  logic          frame_q;             // Frame in progress
  logic          swap;                // Active table update

  pix_beat_s     cur_q;               // Pixel under test
  logic          cur_vld_q;
  logic [PIX_W-1:0] prev_q;           // Left neighbour
  logic          prev_vld_q;
  logic [X_W-1:0] nx_q;               // Column of next beat
  logic [Y_W-1:0] ny_q;               // Row of next beat
  coord_s        cur_pos_q;           // Full-frame position
  logic          accept;              // Input beat taken
  logic          flush;               // Line end pending
  logic          emit;                // Beat into buffer
  logic          buf_ready;
  logic [DEPTH-1:0] hits;             // Per-entry match
  logic [PIX_W-1:0] right;            // Right neighbour
  logic          right_vld;
  pix_beat_s     out_beat;            // Corrected beat

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  ////////////////////////////////////////////////////////////////////////////
  // Factory list entry, zero beyond its length
  function automatic coord_s factory_entry(input logic [IW-1:0] i);
    coord_s e;
    e = '0;
    for (int k = 0; k < FACTORY_N; k++) begin
      if (int'(i) == k) begin
        e = FACTORY_TBL[k];
      end
    end
    return e;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Copy engine
  ////////////////////////////////////////////////////////////////////////////
  assign last       = (idx_q == IW'(DEPTH - 1));
  assign boot_go    = (st_q == ST_BOOT) && !((idx_q == '0) && i_nvm_fresh);
  assign stage_done = last && (boot_go || (st_q == ST_APPLY)
                      || (st_q == ST_RESTORE));
  assign o_busy     = (st_q != ST_IDLE);

  // Sequencing; commands are ignored while busy
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q  <= ST_BOOT;
      idx_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          idx_q <= '0;
          if (i_restore) begin
            st_q <= ST_RESTORE;
          end else if (i_apply) begin
            st_q <= ST_APPLY;
          end else if (i_save) begin
            st_q <= ST_SAVE;
          end
        end
        ST_BOOT: begin
          if (!boot_go) begin
            st_q <= ST_RESTORE;  // Blank storage takes the factory list
          end else if (last) begin
            st_q <= ST_IDLE;
          end else begin
            idx_q <= idx_q + 1'b1;
          end
        end
        ST_APPLY, ST_SAVE, ST_RESTORE: begin
          if (last) begin
            st_q <= ST_IDLE;
          end else begin
            idx_q <= idx_q + 1'b1;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Working copy: edits when idle, loads during boot and restore
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      work_cnt_q <= '0;
    end else if (boot_go) begin
      work_q[idx_q] <= nvm_q[idx_q];
      if (last) begin
        work_cnt_q <= nvm_cnt_q;
      end
    end else if (st_q == ST_RESTORE) begin
      work_q[idx_q] <= factory_entry(idx_q);
      if (last) begin
        work_cnt_q <= CW'(FACTORY_N);
      end
    end else if (st_q == ST_IDLE) begin
      if (i_count_wr) begin
        // Count above capacity clamps to capacity
        work_cnt_q <= (i_count > CW'(DEPTH)) ? CW'(DEPTH) : i_count;
      end
      if (i_x_wr) begin
        work_q[i_index].x <= i_x;
      end
      if (i_y_wr) begin
        work_q[i_index].y <= i_y;
      end
    end
  end

  // Staged copy, filled by apply, boot and restore
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stage_cnt_q <= '0;
    end else if (boot_go) begin
      stage_q[idx_q] <= nvm_q[idx_q];
      if (last) begin
        stage_cnt_q <= nvm_cnt_q;
      end
    end else if (st_q == ST_RESTORE) begin
      stage_q[idx_q] <= factory_entry(idx_q);
      if (last) begin
        stage_cnt_q <= CW'(FACTORY_N);
      end
    end else if (st_q == ST_APPLY) begin
      stage_q[idx_q] <= work_q[idx_q];
      if (last) begin
        stage_cnt_q <= work_cnt_q;
      end
    end
  end

  // Persistent list: kept across reset, every slot rewritten on save
  always_ff @(posedge i_clk) begin
    if (st_q == ST_SAVE) begin
      nvm_q[idx_q] <= work_q[idx_q];
      if (last) begin
        nvm_cnt_q <= work_cnt_q;
      end
    end else if (st_q == ST_RESTORE) begin
      nvm_q[idx_q] <= factory_entry(idx_q);
      if (last) begin
        nvm_cnt_q <= CW'(FACTORY_N);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active table swap
  ////////////////////////////////////////////////////////////////////////////
  // Only between frames and never during a copy, so no frame mixes tables
  assign swap = pend_q && !frame_q && (st_q == ST_IDLE);

  // Pending flag; a new staging wins over the swap clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pend_q <= 1'b0;
    end else if (stage_done) begin
      pend_q <= 1'b1;
    end else if (swap) begin
      pend_q <= 1'b0;
    end
  end

  // Whole-table transfer into the correction path
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      act_cnt_q <= '0;
    end else if (swap) begin
      act_q     <= stage_q;
      act_cnt_q <= stage_cnt_q;
    end
  end

  // Frame tracking from first pixel to last emitted pixel
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      frame_q <= 1'b0;
    end else if (accept && i_beat.sof) begin
      frame_q <= 1'b1;
    end else if (emit && cur_q.eof) begin
      frame_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read side
  ////////////////////////////////////////////////////////////////////////////
  // Selected entry and count read back
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_x <= '0;
      o_y <= '0;
    end else begin
      o_x <= work_q[i_index].x;
      o_y <= work_q[i_index].y;
    end
  end

  assign o_count     = work_cnt_q;
  assign o_index_err = (CW'(i_index) >= work_cnt_q);

  ////////////////////////////////////////////////////////////////////////////
  // Pixel window
  ////////////////////////////////////////////////////////////////////////////
  // A line end is held one extra cycle to be sent without right neighbour
  assign flush   = cur_vld_q && cur_q.eol;
  assign o_ready = buf_ready && !flush;
  assign accept  = i_valid && o_ready;
  assign emit    = (accept && cur_vld_q) || (flush && buf_ready);
  assign right     = i_beat.data;
  assign right_vld = accept;

  // Position of each beat, offsets added for full-frame terms
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      nx_q      <= '0;
      ny_q      <= '0;
      cur_pos_q <= '0;
    end else if (accept) begin
      if (i_beat.sof) begin
        cur_pos_q.x <= i_roi_off_x;
        cur_pos_q.y <= i_roi_off_y;
      end else begin
        cur_pos_q.x <= X_W'(nx_q + i_roi_off_x);
        cur_pos_q.y <= Y_W'(ny_q + i_roi_off_y);
      end
      if (i_beat.eol) begin
        nx_q <= '0;
        ny_q <= i_beat.sof ? Y_W'(1) : Y_W'(ny_q + 1'b1);
      end else begin
        nx_q <= i_beat.sof ? X_W'(1) : X_W'(nx_q + 1'b1);
        ny_q <= i_beat.sof ? '0 : ny_q;
      end
    end
  end

  // Centre and left neighbour shift
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cur_q      <= '0;
      cur_vld_q  <= 1'b0;
      prev_q     <= '0;
      prev_vld_q <= 1'b0;
    end else if (accept) begin
      cur_q      <= i_beat;
      cur_vld_q  <= 1'b1;
      prev_q     <= cur_q.data;
      prev_vld_q <= cur_vld_q && !i_beat.sof;
    end else if (flush && buf_ready) begin
      cur_vld_q  <= 1'b0;
      prev_vld_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table match and replacement
  ////////////////////////////////////////////////////////////////////////////
  // Compare against every live active entry
  for (genvar g = 0; g < DEPTH; g++) begin : g_match
    assign hits[g] = (CW'(g) < act_cnt_q) && (act_q[g] == cur_pos_q);
  end

  // Substitute value for listed pixels
  always_comb begin
    logic [PIX_W:0] sum;
    sum      = '0;
    out_beat = cur_q;
    if (i_enable && (hits != '0)) begin
      if (i_mode == MODE_HIGHLIGHT) begin
        out_beat.data = i_pix_max;
      end else if (prev_vld_q && right_vld) begin
        sum           = {1'b0, prev_q} + {1'b0, right};
        out_beat.data = sum[PIX_W:1];
      end else if (prev_vld_q) begin
        out_beat.data = prev_q;
      end else if (right_vld) begin
        out_beat.data = right;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output buffer
  ////////////////////////////////////////////////////////////////////////////
  pix_skid_fifo #(
    .W     ($bits(pix_beat_s)),
    .DEPTH (BUF_DEPTH)
  ) u_out_buf (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (emit),
    .i_data  (out_beat),
    .o_ready (buf_ready),
    .o_valid (o_valid),
    .o_data  (o_beat),
    .i_ready (i_ready)
  );

endmodule

`default_nettype wire

//--- sim/dpc_checker.sv
`timescale 1ns/1ps
`default_nettype none

module dpc_checker
  import dpc_pkg::*;
#(
  parameter int DEPTH = TBL_DEPTH  // Table capacity
) (
  // Clock, reset and stream
  input wire logic                       i_clk, i_rst, i_valid, o_ready,
  input wire logic                       o_valid, i_ready, i_enable,
  input wire pix_beat_s                  i_beat, o_beat,
  // Correction control
  input wire corr_mode_e                 i_mode,
  input wire logic [PIX_W-1:0]           i_pix_max,
  input wire logic [X_W-1:0]             i_roi_off_x, i_x, o_x,
  input wire logic [Y_W-1:0]             i_roi_off_y, i_y, o_y,
  // Table editing and commands
  input wire logic [$clog2(DEPTH+1)-1:0] i_count, o_count,
  input wire logic [$clog2(DEPTH)-1:0]   i_index,
  input wire logic                       i_count_wr, o_index_err, i_x_wr,
  input wire logic                       i_y_wr, i_apply, i_save, i_restore,
  input wire logic                       i_nvm_fresh, o_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Length of the current busy run
  logic [7:0] busy_run_q;  // Cycles since busy rose
  always_ff @(posedge i_clk) begin
    if (i_rst || !o_busy) begin
      busy_run_q <= 8'h00;
    end else begin
      busy_run_q <= busy_run_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_index_err;
    o_index_err == ({1'b0, i_index} >= o_count);
  endproperty
  a_index_err: assert property (p_index_err)
    else $error("index error flag wrong");
  property p_cmd_busy;
    (!o_busy && (i_apply || i_save || i_restore)) |=> o_busy;
  endproperty
  a_cmd_busy: assert property (p_cmd_busy)
    else $error("command did not start copy");
  property p_busy_bound;
    int'(busy_run_q) <= DEPTH + 1;
  endproperty
  a_busy_bound: assert property (p_busy_bound)
    else $error("table copy runs too long");
  property p_x_wr;
    (!o_busy && i_x_wr) ##1 $stable(i_index) |=> o_x == $past(i_x, 2);
  endproperty
  a_x_wr: assert property (p_x_wr)
    else $error("column write not read back");
  property p_y_wr;
    (!o_busy && i_y_wr) ##1 $stable(i_index) |=> o_y == $past(i_y, 2);
  endproperty
  a_y_wr: assert property (p_y_wr)
    else $error("row write not read back");
  property p_count_wr;
    (!o_busy && i_count_wr && i_count <= DEPTH) |=>
      o_count == $past(i_count);
  endproperty
  a_count_wr: assert property (p_count_wr)
    else $error("count write lost");
  property p_count_max;
    o_count <= DEPTH;
  endproperty
  a_count_max: assert property (p_count_max)
    else $error("count above capacity");
  property p_hold;
    (o_valid && !i_ready) |=> (o_valid && $stable(o_beat));
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled beat changed");

  // Main scenarios
  c_apply: cover property (!o_busy && i_apply);
  c_full:  cover property (i_valid && !o_ready);
  c_high:  cover property (o_valid && i_ready && o_beat.data == i_pix_max);
endmodule

bind defective_pixel_corrector dpc_checker #(.DEPTH(DEPTH)) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid), .o_ready(o_ready),
  .o_valid(o_valid), .i_ready(i_ready), .i_enable(i_enable),
  .i_beat(i_beat), .o_beat(o_beat), .i_mode(i_mode),
  .i_pix_max(i_pix_max), .i_roi_off_x(i_roi_off_x), .i_x(i_x), .o_x(o_x),
  .i_roi_off_y(i_roi_off_y), .i_y(i_y), .o_y(o_y), .i_count(i_count),
  .o_count(o_count), .i_index(i_index), .i_count_wr(i_count_wr),
  .o_index_err(o_index_err), .i_x_wr(i_x_wr), .i_y_wr(i_y_wr),
  .i_apply(i_apply), .i_save(i_save), .i_restore(i_restore),
  .i_nvm_fresh(i_nvm_fresh), .o_busy(o_busy));

`default_nettype wire

//--- sim/pix_source.sv
`timescale 1ns/1ps
`default_nettype none

module pix_source
  import dpc_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Frame control
  input  wire logic i_start,   // Begin one 4x2 frame
  input  wire logic i_slow,    // Insert extra idle cycles
  // Stream out
  input  wire logic i_ready,
  output logic      o_valid,
  output pix_beat_s o_beat
);
  // Frame samples, two lines of four
  localparam logic [11:0] PIX [8] = '{12'h00a, 12'h014, 12'h05a, 12'h028,
                                      12'h032, 12'h03c, 12'h046, 12'h050};
  logic [2:0] idx_q;  // Next beat in frame
  logic       run_q;  // Frame in progress
  logic       gap_q;  // Toggles for slow pacing

  // Beat with framing flags for position n
  function automatic pix_beat_s beat_at(input logic [2:0] n);
    return '{sof: n == 3'd0, eol: n[1:0] == 2'd3, eof: n == 3'd7,
             data: PIX[n]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Hold each beat until taken, then release with scrambled data
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_beat  <= '0;
      idx_q   <= 3'd0;
      run_q   <= 1'b0;
      gap_q   <= 1'b0;
    end else if (i_start) begin
      run_q <= 1'b1;
      idx_q <= 3'd0;
    end else begin
      gap_q <= ~gap_q;
      if (o_valid && i_ready) begin
        o_valid     <= 1'b0;
        o_beat.data <= ~o_beat.data;
        idx_q       <= idx_q + 3'd1;
        if (idx_q == 3'd7) begin
          run_q <= 1'b0;
        end
      end else if (run_q && !o_valid && !(i_slow && gap_q)) begin
        o_valid <= 1'b1;
        o_beat  <= beat_at(idx_q);
      end
    end
  end
endmodule

`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
  bad_count++; $display("Error at %0t: got %0h want %0h", $time, got, exp); \
  end end

module tb;
  import dpc_pkg::*;
  localparam logic [11:0] PIX [8] = '{12'h00a, 12'h014, 12'h05a, 12'h028,
                                      12'h032, 12'h03c, 12'h046, 12'h050};
  logic       clk, rst, v_in, rdy_in, v_out, rdy, en, cwr, xwr, ywr;
  logic       apl, sav, rsto, fresh, busy, ierr, start, slow;
  pix_beat_s  b_in, b_out;
  corr_mode_e mode;
  logic [11:0] xin, yin, xo, yo;
  logic [2:0] cnt_in, cnt_o;
  logic [1:0] idx;
  pix_beat_s  got_q [$];   // Accepted output beats
  int         bad_count, samples_checked;

  // Upstream pixel source
  pix_source src (.i_clk(clk), .i_rst(rst), .i_start(start),
    .i_slow(slow), .i_ready(rdy_in), .o_valid(v_in), .o_beat(b_in));
  // Device with a small table; window offset 14,8
  defective_pixel_corrector #(.DEPTH(4)) dut (.i_clk(clk), .i_rst(rst),
    .i_valid(v_in), .i_beat(b_in), .o_ready(rdy_in), .o_valid(v_out),
    .o_beat(b_out), .i_ready(rdy), .i_enable(en), .i_mode(mode),
    .i_pix_max(12'hfff), .i_roi_off_x(12'h00e), .i_roi_off_y(12'h008),
    .i_count_wr(cwr), .i_count(cnt_in), .o_count(cnt_o), .i_index(idx),
    .o_index_err(ierr), .i_x_wr(xwr), .i_x(xin), .i_y_wr(ywr), .i_y(yin),
    .o_x(xo), .o_y(yo), .i_apply(apl), .i_save(sav), .i_restore(rsto),
    .i_nvm_fresh(fresh), .o_busy(busy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Collect every beat accepted downstream
  always @(posedge clk) begin
    if (!rst && v_out && rdy) begin
      got_q.push_back(b_out);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      tick(1);
      n++;
    end
    if (busy !== 1'b0) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  task automatic do_reset(input logic f);
    fresh <= f;
    rst   <= 1'b1;
    tick(6);
    rst   <= 1'b0;
    tick(1);
    wait_idle();
  endtask
  // Pulse apply (0), save (1) or restore (2)
  task automatic pulse_cmd(input int k);
    apl  <= (k == 0);
    sav  <= (k == 1);
    rsto <= (k == 2);
    tick(1);
    {apl, sav, rsto} <= 3'b000;
    tick(2);
    wait_idle();
  endtask
  task automatic edit_entry(input logic [2:0] c, input logic [1:0] i,
                            input logic [11:0] x, input logic [11:0] y);
    cwr <= 1'b1; cnt_in <= c; idx <= i;
    tick(1);
    cwr <= 1'b0; xwr <= 1'b1; ywr <= 1'b1; xin <= x; yin <= y;
    tick(1);
    xwr <= 1'b0; ywr <= 1'b0;
    tick(2);
  endtask
  // Send one frame; expect e2 at beat 2, e4 at beat 4, others unchanged
  task automatic frame(input logic e, input corr_mode_e m, input logic sl,
                       input logic st, input logic [11:0] e2, e4);
    pix_beat_s exp;
    int n;
    got_q.delete();
    en <= e; mode <= m; slow <= sl; rdy <= !st; start <= 1'b1;
    tick(1);
    start <= 1'b0;
    n = 0;
    while (st && rdy_in !== 1'b0 && n < 50) begin
      tick(1);
      n++;
    end
    if (st) begin
      tick(6);
      `CHK(rdy_in, 1'b0)
      rdy <= 1'b1;
    end
    n = 0;
    while (got_q.size() < 8 && n < 300) begin
      tick(1);
      n++;
    end
    if (got_q.size() < 8) begin
      bad_count++;
      report_and_stop();
    end
    tick(2);
    `CHK(v_out, 1'b0)
    for (int i = 0; i < 8; i++) begin
      // Framing flags travel with the sample unchanged
      exp = '{sof: i == 0, eol: i % 4 == 3, eof: i == 7,
              data: (i == 2) ? e2 : (i == 4) ? e4 : PIX[i]};
      `CHK(got_q[i], exp)
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; fresh = 1'b1; en = 1'b0; mode = MODE_AVERAGE; rdy = 1'b1;
    cwr = 1'b0; xwr = 1'b0; ywr = 1'b0; apl = 1'b0; sav = 1'b0;
    rsto = 1'b0; start = 1'b0; slow = 1'b0; cnt_in = 3'd0; idx = 2'd0;
    xin = 12'h000; yin = 12'h000; bad_count = 0; samples_checked = 0;
    do_reset(1'b1);
    `CHK(cnt_o, 3'd2)
    idx <= 2'd1;
    tick(2);
    `CHK(xo, 12'h123)
    `CHK(yo, 12'h045)
    frame(1'b0, MODE_AVERAGE, 1'b0, 1'b0, 12'h05a, 12'h032);
    frame(1'b1, MODE_AVERAGE, 1'b0, 1'b1, 12'h01e, 12'h032);
    frame(1'b1, MODE_HIGHLIGHT, 1'b1, 1'b0, 12'hfff, 12'h032);
    edit_entry(3'd3, 2'd2, 12'h00e, 12'h009);
    `CHK(cnt_o, 3'd3)
    `CHK(ierr, 1'b0)
    `CHK(xo, 12'h00e)
    `CHK(yo, 12'h009)
    idx <= 2'd3;
    tick(2);
    `CHK(ierr, 1'b1)
    frame(1'b1, MODE_AVERAGE, 1'b0, 1'b0, 12'h01e, 12'h032);
    pulse_cmd(0);
    frame(1'b1, MODE_AVERAGE, 1'b0, 1'b0, 12'h01e, 12'h03c);
    pulse_cmd(1);
    do_reset(1'b0);
    `CHK(cnt_o, 3'd3)
    frame(1'b1, MODE_AVERAGE, 1'b0, 1'b0, 12'h01e, 12'h03c);
    edit_entry(3'd1, 2'd0, 12'h010, 12'h008);
    pulse_cmd(1);
    do_reset(1'b0);
    `CHK(cnt_o, 3'd1)
    frame(1'b1, MODE_AVERAGE, 1'b0, 1'b0, 12'h01e, 12'h032);
    pulse_cmd(2);
    `CHK(cnt_o, 3'd2)
    do_reset(1'b0);
    `CHK(cnt_o, 3'd2)
    idx <= 2'd1;
    tick(2);
    `CHK(xo, 12'h123)
    report_and_stop();
  end
endmodule

`default_nettype wire
